// File: verilog/lsz_pkg.sv
/*
 * Constants for the limit-switch zone compare block: buffer-memory word
 * addresses, table geometry, reset values and the sampling period.
 * Assumes a 100 MHz clk_i and a host that reaches the block through a
 * word-wide buffer-memory port on the same clock.
 */
package lsz_pkg;
	// ----------------------------------------------------------------
	// Geometry
	// ----------------------------------------------------------------
	localparam int NUM_CH = 16;
	localparam int NUM_ZONE = 10;
	localparam int NUM_RET = 8;
	localparam int CH_WORDS = 41;
	localparam int AREA_WORDS = 656;
	localparam logic [3:0] MAX_ZONE = 4'ha;
	localparam logic [3:0] PROG_NONE = 4'h9;
	localparam logic [3:0] PROG_MAX = 4'h8;

	// ----------------------------------------------------------------
	// Buffer-memory word addresses
	// ----------------------------------------------------------------
	localparam logic [10:0] A_STATUS = 11'h002;
	localparam logic [10:0] A_ANSWER = 11'h003;
	localparam logic [10:0] A_PSEL1 = 11'h009;
	localparam logic [10:0] A_ERROR = 11'h00a;
	localparam logic [10:0] A_STORE = 11'h00b;
	localparam logic [10:0] A_AREA_LO = 11'h00c;
	localparam logic [10:0] A_AREA_HI = 11'h29b;
	localparam logic [10:0] A_SCALE_L = 11'h2c0;
	localparam logic [10:0] A_SCALE_H = 11'h2c1;
	localparam logic [10:0] A_MIN_L = 11'h2c3;
	localparam logic [10:0] A_MIN_H = 11'h2c4;
	localparam logic [10:0] A_OFFL = 11'h2df;
	localparam logic [10:0] A_PSEL2 = 11'h3f1;
	localparam logic [15:0] ERR_BIAS = 16'h03e8;

	// ----------------------------------------------------------------
	// Reset values and timing
	// ----------------------------------------------------------------
	localparam logic [15:0] PSEL_RST = 16'h0009;
	localparam logic [31:0] SCALE_RST = 32'hffff_ffff;
	localparam int CLK_PERIOD_NS = 10;
	localparam int SAMPLE_TIME_NS = 1600000;
	localparam int SAMPLE_CYC = SAMPLE_TIME_NS / CLK_PERIOD_NS;
endpackage

// File: verilog/lsz_zone_if.sv
/*
 * Carrier between the top and one channel comparator: zone data, the
 * sampled position and detection range in; hit and error out.
 * Assumes all signals live on clk_i.
 */
`timescale 1ns/1ps
interface lsz_zone_if (
	input wire logic clk_i,
	input wire logic rstn_i
);
	logic [3:0] cnt;
	logic [31:0] on_pos [lsz_pkg::NUM_ZONE];
	logic [31:0] off_pos [lsz_pkg::NUM_ZONE];
	logic [31:0] pos;
	logic [31:0] rng_lo;
	logic [31:0] rng_hi;
	logic hit;
	logic err;
	logic [3:0] err_zone;
	modport cmp (input clk_i, rstn_i, cnt, on_pos, off_pos, pos, rng_lo, rng_hi,
		output hit, err, err_zone);
	modport src (output cnt, on_pos, off_pos, pos, rng_lo, rng_hi,
		input hit, err, err_zone);
endinterface

// File: verilog/lsz_zone_cmp.sv
/*
 * One channel's zone comparator: decides the channel output from up to
 * ten ON/OFF pairs and checks the pairs for range and ordering faults.
 * Assumes zone data is stable between program loads.
 */
`timescale 1ns/1ps
module lsz_zone_cmp (
	lsz_zone_if.cmp z // Zone data in, hit and error out
);
	logic [3:0] eff;
	logic on_mode;
	logic [lsz_pkg::NUM_ZONE-1:0] used;
	logic [lsz_pkg::NUM_ZONE-1:0] hit_k;
	logic [lsz_pkg::NUM_ZONE-1:0] bad_k;

	assign eff = (z.cnt > lsz_pkg::MAX_ZONE) ? lsz_pkg::MAX_ZONE : z.cnt;
	// Dog zero decides whether the channel lists ON areas or OFF areas
	assign on_mode = z.on_pos[0] < z.off_pos[0];

	// ----------------------------------------------------------------
	// Per-zone compare and check
	// ----------------------------------------------------------------
	for (genvar k = 0; k < lsz_pkg::NUM_ZONE; k++) begin : g_zone
		logic in_on;
		logic in_off;
		logic range_bad;
		logic order_bad;
		logic next_bad;
		assign used[k] = 4'(k) < eff;
		assign in_on = (z.pos >= z.on_pos[k]) && (z.pos < z.off_pos[k]);
		assign in_off = (z.pos >= z.off_pos[k]) && (z.pos < z.on_pos[k]);
		assign hit_k[k] = used[k] && (on_mode ? in_on : in_off);
		assign range_bad = (z.on_pos[k] < z.rng_lo) || (z.on_pos[k] > z.rng_hi) ||
			(z.off_pos[k] < z.rng_lo) || (z.off_pos[k] > z.rng_hi);
		assign order_bad = on_mode ? (z.on_pos[k] >= z.off_pos[k]) :
			(z.on_pos[k] <= z.off_pos[k]);
		if (k < lsz_pkg::NUM_ZONE - 1) begin : g_next
			assign next_bad = used[k+1] && (on_mode ? (z.off_pos[k] >= z.on_pos[k+1]) :
				(z.on_pos[k] >= z.off_pos[k+1]));
		end else begin : g_last
			assign next_bad = 1'b0;
		end
		assign bad_k[k] = used[k] && (range_bad || order_bad || next_bad);
	end

	// Zero zones makes the channel inoperative, so it stays off in either mode
	assign z.hit = (eff != 4'h0) && (on_mode ? (|hit_k) : !(|hit_k));
	assign z.err = |bad_k;

	always_comb begin
		z.err_zone = 4'h0;
		for (int i = lsz_pkg::NUM_ZONE - 1; i >= 0; i--) begin
			if (bad_k[i]) begin
				z.err_zone = 4'(i);
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	zero_cnt_off_a: assert property (@(posedge z.clk_i) disable iff (!z.rstn_i)
		(z.cnt == 4'h0) |-> !z.hit) else $error("channel with no zones is on");
	clamp_ten_a: assert property (@(posedge z.clk_i) disable iff (!z.rstn_i)
		(z.cnt > 4'ha) |-> (used == 10'h3ff)) else $error("zone count not clamped");
endmodule // lsz_zone_cmp

// File: verilog/lsz_limit_switch.sv
/*
 * Programmable limit-switch logic for one axis: buffer-memory register
 * port, nine zone programs, program loader and sixteen channel outputs
 * refreshed on the sampling tick.
 * Assumes the host port and the position word come from logic on clk_i,
 * and that retained storage keeps its content across rstn_i.
 */
`timescale 1ns/1ps
module lsz_limit_switch #(
	parameter int SAMPLE_CYC = lsz_pkg::SAMPLE_CYC // Cycles per sample
) (
	input wire logic clk_i, // 100 MHz clock
	input wire logic rstn_i, // Async reset, active low
	input wire logic host_ready_output_i, // Host ready bit
	input wire logic [10:0] bm_addr_i, // Buffer word address
	input wire logic bm_wr_i, // Write strobe
	input wire logic [15:0] bm_wdata_i, // Write data
	input wire logic bm_rd_i, // Read strobe
	input wire logic [31:0] pos_i, // Scaled absolute position
	output logic [15:0] bm_rdata_o, // Read data, one cycle after rd
	output logic module_online_input_o, // Online status bit
	output logic [15:0] switch_output_o, // Channel outputs
	output logic [15:0] err_code_o // Current error code, 0 if none
);
	typedef enum logic [1:0] {LSZ_IDLE, LSZ_LOAD, LSZ_STORE} lsz_cp_e;

	logic [15:0] area_r [lsz_pkg::AREA_WORDS];
	logic [15:0] wm_r [lsz_pkg::AREA_WORDS];
	logic [15:0] ret_r [lsz_pkg::NUM_RET][lsz_pkg::AREA_WORDS];
	logic [15:0] psel1_r;
	logic [15:0] psel2_r;
	logic [3:0] active_r;
	logic [31:0] scale_r;
	logic [31:0] min_r;
	logic hold_r;
	logic online_r;
	logic [15:0] sw_r;
	logic [15:0] err_r;
	logic [15:0] rdata_r;
	logic [31:0] pos_r;
	logic [17:0] div_r;
	logic tick_r;
	lsz_cp_e cp_r;
	logic [9:0] cp_idx_r;
	logic [3:0] cp_prog_r;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	logic in_area;
	logic [9:0] area_idx;
	logic wr_area;
	logic wr_psel1;
	logic wr_store;
	logic psel_ok;
	logic store_ok;
	logic cp_last;
	logic [15:0] src_word;
	logic [15:0] sw_nxt;
	logic [15:0] hit_w;
	logic [15:0] cherr_w;
	logic [3:0] zerr_w [lsz_pkg::NUM_CH];
	logic [31:0] rng_hi;
	logic [15:0] err_nxt;
	logic [15:0] rd_nxt;

	assign in_area = (bm_addr_i >= lsz_pkg::A_AREA_LO) && (bm_addr_i <= lsz_pkg::A_AREA_HI);
	assign area_idx = 10'(bm_addr_i - lsz_pkg::A_AREA_LO);
	assign wr_area = bm_wr_i && in_area;
	assign wr_psel1 = bm_wr_i && (bm_addr_i == lsz_pkg::A_PSEL1);
	assign wr_store = bm_wr_i && (bm_addr_i == lsz_pkg::A_STORE);
	// Values above 9 are kept in the word but start no load
	assign psel_ok = bm_wdata_i <= {12'h000, lsz_pkg::PROG_NONE};
	assign store_ok = (bm_wdata_i != 16'h0000) && (bm_wdata_i <= {12'h000, lsz_pkg::PROG_MAX});
	assign cp_last = cp_idx_r == 10'(lsz_pkg::AREA_WORDS - 1);
	// Program 9 loads an empty table; a select of 0 reloads program 0 with or without 9 first
	assign src_word = (cp_prog_r == 4'h0) ? area_r[cp_idx_r] :
		(cp_prog_r == lsz_pkg::PROG_NONE) ? 16'h0000 :
		ret_r[3'(cp_prog_r - 4'h1)][cp_idx_r];
	assign rng_hi = min_r + scale_r - 32'h0000_0001;

	// ----------------------------------------------------------------
	// Host-written registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			psel1_r <= lsz_pkg::PSEL_RST;
			psel2_r <= lsz_pkg::PSEL_RST;
			scale_r <= lsz_pkg::SCALE_RST;
			min_r <= '0;
			hold_r <= 1'b0;
		end else if (bm_wr_i) begin
			if (bm_addr_i == lsz_pkg::A_PSEL1) psel1_r <= bm_wdata_i;
			if (bm_addr_i == lsz_pkg::A_PSEL2) psel2_r <= bm_wdata_i;
			if (bm_addr_i == lsz_pkg::A_SCALE_L) scale_r[15:0] <= bm_wdata_i;
			if (bm_addr_i == lsz_pkg::A_SCALE_H) scale_r[31:16] <= bm_wdata_i;
			if (bm_addr_i == lsz_pkg::A_MIN_L) min_r[15:0] <= bm_wdata_i;
			if (bm_addr_i == lsz_pkg::A_MIN_H) min_r[31:16] <= bm_wdata_i;
			if (bm_addr_i == lsz_pkg::A_OFFL) hold_r <= bm_wdata_i[0];
		end
	end

	// Program zero lives in the volatile buffer area
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			for (int i = 0; i < lsz_pkg::AREA_WORDS; i++) area_r[i] <= '0;
		end else if (wr_area) begin
			area_r[area_idx] <= bm_wdata_i;
		end
	end

	// No reset on purpose: this array stands for the retained store
	always_ff @(posedge clk_i) begin
		if (cp_r == LSZ_STORE) begin
			ret_r[3'(cp_prog_r - 4'h1)][cp_idx_r] <= area_r[cp_idx_r];
		end
	end

	// ----------------------------------------------------------------
	// Copy engine: loads the working table or stores a program
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cp_r <= LSZ_LOAD;
			cp_idx_r <= '0;
			cp_prog_r <= lsz_pkg::PROG_NONE;
			active_r <= lsz_pkg::PROG_NONE;
		end else if (wr_psel1 && psel_ok) begin
			// A new selection restarts any load in progress and abandons a store in progress
			cp_r <= LSZ_LOAD;
			cp_idx_r <= '0;
			cp_prog_r <= bm_wdata_i[3:0];
		end else if (wr_store && store_ok && (cp_r == LSZ_IDLE)) begin
			cp_r <= LSZ_STORE;
			cp_idx_r <= '0;
			cp_prog_r <= bm_wdata_i[3:0];
		end else begin
			case (cp_r)
				LSZ_LOAD: begin
					cp_idx_r <= cp_idx_r + 10'h001;
					if (cp_last) begin
						cp_r <= LSZ_IDLE;
						active_r <= cp_prog_r;
					end
				end
				LSZ_STORE: begin
					cp_idx_r <= cp_idx_r + 10'h001;
					if (cp_last) cp_r <= LSZ_IDLE;
				end
				default: cp_r <= LSZ_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			for (int i = 0; i < lsz_pkg::AREA_WORDS; i++) wm_r[i] <= '0;
		end else if (cp_r == LSZ_LOAD) begin
			wm_r[cp_idx_r] <= src_word;
		end
	end

	// ----------------------------------------------------------------
	// Channel comparators
	// ----------------------------------------------------------------
	for (genvar g = 0; g < lsz_pkg::NUM_CH; g++) begin : g_ch
		localparam int BASE = g * lsz_pkg::CH_WORDS;
		lsz_zone_if zif (.clk_i(clk_i), .rstn_i(rstn_i));
		assign zif.cnt = wm_r[BASE][3:0];
		assign zif.pos = pos_r;
		assign zif.rng_lo = min_r;
		assign zif.rng_hi = rng_hi;
		for (genvar k = 0; k < lsz_pkg::NUM_ZONE; k++) begin : g_z
			assign zif.on_pos[k] = {wm_r[BASE+2+4*k], wm_r[BASE+1+4*k]};
			assign zif.off_pos[k] = {wm_r[BASE+4+4*k], wm_r[BASE+3+4*k]};
		end
		lsz_zone_cmp u_cmp (.z(zif.cmp));
		assign hit_w[g] = zif.hit;
		assign cherr_w[g] = zif.err;
		assign zerr_w[g] = zif.err_zone;
	end

	// Lowest faulty channel wins; code points at that zone's ON low word
	always_comb begin
		err_nxt = 16'h0000;
		for (int c = lsz_pkg::NUM_CH - 1; c >= 0; c--) begin
			if (cherr_w[c]) begin
				err_nxt = lsz_pkg::ERR_BIAS + 16'(lsz_pkg::A_AREA_LO) +
					16'(c * lsz_pkg::CH_WORDS) + 16'h0001 + 16'({zerr_w[c], 2'b00});
			end
		end
	end

	// ----------------------------------------------------------------
	// Sampling, online state and outputs
	// ----------------------------------------------------------------
	// Offline without hold forces all off, offline with hold keeps them; online only the tick refreshes
	assign sw_nxt = !online_r ? (hold_r ? sw_r : 16'h0000) :
		(tick_r ? hit_w : sw_r);

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			div_r <= '0;
			tick_r <= 1'b0;
		end else begin
			tick_r <= div_r == 18'(SAMPLE_CYC - 1);
			div_r <= (div_r == 18'(SAMPLE_CYC - 1)) ? 18'h0_0000 : div_r + 18'h0_0001;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			online_r <= 1'b0;
			pos_r <= '0;
			sw_r <= '0;
			err_r <= '0;
		end else begin
			online_r <= host_ready_output_i;
			if (tick_r && online_r) pos_r <= pos_i;
			sw_r <= sw_nxt;
			err_r <= err_nxt;
		end
	end

	always_comb begin
		case (bm_addr_i)
			lsz_pkg::A_STATUS: rd_nxt = sw_r;
			lsz_pkg::A_ANSWER: rd_nxt = {12'h000, active_r};
			lsz_pkg::A_PSEL1: rd_nxt = psel1_r;
			lsz_pkg::A_PSEL2: rd_nxt = psel2_r;
			lsz_pkg::A_ERROR: rd_nxt = err_r;
			lsz_pkg::A_STORE: rd_nxt = {15'h0000, cp_r != LSZ_IDLE};
			lsz_pkg::A_SCALE_L: rd_nxt = scale_r[15:0];
			lsz_pkg::A_SCALE_H: rd_nxt = scale_r[31:16];
			lsz_pkg::A_MIN_L: rd_nxt = min_r[15:0];
			lsz_pkg::A_MIN_H: rd_nxt = min_r[31:16];
			lsz_pkg::A_OFFL: rd_nxt = {15'h0000, hold_r};
			default: rd_nxt = in_area ? area_r[area_idx] : 16'h0000;
		endcase
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) rdata_r <= '0;
		else if (bm_rd_i) rdata_r <= rd_nxt;
	end

	assign bm_rdata_o = rdata_r;
	assign module_online_input_o = online_r;
	assign switch_output_o = sw_r;
	assign err_code_o = err_r;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	online_follow_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		host_ready_output_i |=> module_online_input_o) else $error("online not set");
	offline_drop_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!host_ready_output_i |=> !module_online_input_o) else $error("online not cleared");
	offline_off_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(!module_online_input_o && !hold_r) |=> (switch_output_o == 16'h0000))
		else $error("outputs not off while offline");
	offline_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(!module_online_input_o && hold_r) |=> $stable(switch_output_o))
		else $error("outputs not held while offline");
	sample_only_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(module_online_input_o && !tick_r) |=> $stable(switch_output_o))
		else $error("outputs changed between samples");
	tick_space_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		tick_r |=> !tick_r [*8]) else $error("sample ticks too close");
	status_read_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(bm_rd_i && (bm_addr_i == lsz_pkg::A_STATUS)) |=> (bm_rdata_o == $past(sw_r)))
		else $error("status word wrong");
	psel_load_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(wr_psel1 && psel_ok) |=> ((cp_r == LSZ_LOAD) && (cp_prog_r == $past(bm_wdata_i[3:0]))))
		else $error("program select did not start load");
	err_bias_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(err_code_o != 16'h0000) |-> (err_code_o >= 16'h03f4)) else $error("error code too low");
endmodule // lsz_limit_switch

// File: testbench/lsz_host_model.sv
/*
 * Host controller model: ready bit, sensed position and one-cycle
 * buffer-memory strobes for the limit-switch block.
 * Assumes the block samples every input on the rising edge of clk_i.
 */
`timescale 1ns/1ps
module lsz_host_model (
	input wire logic clk_i, // Clock
	input wire logic [15:0] rdata_i, // Read data from the block
	output logic ready_o, // Host ready bit
	output logic [10:0] addr_o, // Word address
	output logic wr_o, // Write strobe
	output logic [15:0] wdata_o, // Write data
	output logic rd_o, // Read strobe
	output logic [31:0] pos_o // Sensed position
);
	initial begin
		ready_o = 1'b0;
		addr_o = 11'h7ff;
		wr_o = 1'b0;
		wdata_o = 16'h0000;
		rd_o = 1'b0;
		pos_o = 32'h0000_0000;
	end
	// Released lines show the inverse, so a stale value never passes as live
	task automatic wr(input logic [10:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~d;
	endtask
	task automatic rd(input logic [10:0] a, output logic [15:0] d);
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		@(posedge clk_i);
		d = rdata_i;
	endtask
	task automatic wr32(input logic [10:0] a, input logic [31:0] v);
		wr(a, v[15:0]);
		wr(a + 11'h001, v[31:16]);
	endtask
	task automatic set_ready(input logic v);
		@(posedge clk_i);
		ready_o <= v;
	endtask
	task automatic set_pos(input logic [31:0] p);
		@(posedge clk_i);
		pos_o <= p;
	endtask
	// Loader walks 656 words after a select write
	task automatic select(input logic [15:0] p);
		wr(lsz_pkg::A_PSEL1, p);
		repeat (670) @(posedge clk_i);
	endtask
	task automatic reload0;
		select(16'h0009);
		select(16'h0000);
	endtask
endmodule // lsz_host_model

// File: testbench/tb.sv
/*
 * Self-checking bench for the limit-switch block with a host model.
 * Assumes a short sampling period of 16 cycles for simulation.
 */
`timescale 1ns/1ps
module tb;
	localparam int SCYC = 16;
	logic clk_i;
	logic rstn_i;
	logic ready, wr, rd;
	logic [10:0] addr;
	logic [15:0] wdata, rdata, sw, err;
	logic [31:0] pos;
	logic online;
	int bad_count = 0;
	int checks = 0;
	int pos_tab [6] = '{100, 250, 400, 500, 1185, 50};
	logic [15:0] exp_tab [6] = '{16'h0003, 16'h0000, 16'h0001, 16'h0002, 16'h0006, 16'h0002};

	lsz_host_model host (.clk_i(clk_i), .rdata_i(rdata), .ready_o(ready), .addr_o(addr),
		.wr_o(wr), .wdata_o(wdata), .rd_o(rd), .pos_o(pos));
	lsz_limit_switch #(.SAMPLE_CYC(SCYC)) uut (.clk_i(clk_i), .rstn_i(rstn_i),
		.host_ready_output_i(ready), .bm_addr_i(addr), .bm_wr_i(wr), .bm_wdata_i(wdata),
		.bm_rd_i(rd), .pos_i(pos), .bm_rdata_o(rdata), .module_online_input_o(online),
		.switch_output_o(sw), .err_code_o(err));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	task automatic end_of_test;
		if (bad_count == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_rd(input string n, input logic [10:0] a, input logic [15:0] e);
		logic [15:0] d;
		host.rd(a, d);
		chk(n, e, d);
	endtask
	// Output lags the sampled position by one tick
	task automatic ticks;
		repeat (3 * SCYC + 4) @(posedge clk_i);
	endtask
	task automatic zone(input int c, input int k, input logic [31:0] on, input logic [31:0] off);
		host.wr32(11'(12 + 41 * c + 1 + 4 * k), on);
		host.wr32(11'(12 + 41 * c + 3 + 4 * k), off);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		chk_rd("select", lsz_pkg::A_PSEL1, lsz_pkg::PSEL_RST);
		chk("online", 16'h0000, {15'h0000, online});
		chk("switch", 16'h0000, sw);
		host.wr(lsz_pkg::A_PSEL2, 16'h0005);
		chk_rd("select2", lsz_pkg::A_PSEL2, 16'h0005);
		chk_rd("unmapped", 11'h7ff, 16'h0000);
	endtask
	task automatic t_zones;
		host.wr(11'h00c, 16'h0002);
		zone(0, 0, 100, 250);
		zone(0, 1, 350, 500);
		host.wr(11'h035, 16'h0001);
		zone(1, 0, 500, 200);
		host.wr(11'h05e, 16'h001b);
		for (int k = 0; k < 10; k++) begin
			zone(2, k, 1000 + 20 * k, 1010 + 20 * k);
		end
		host.wr(11'h087, 16'h0010);
		zone(3, 0, 0, 100);
		host.select(16'h0000);
		chk_rd("answerback", lsz_pkg::A_ANSWER, 16'h0000);
		chk("error", 16'h0000, err);
		host.set_ready(1'b1);
		repeat (2) @(posedge clk_i);
		chk("online", 16'h0001, {15'h0000, online});
		for (int i = 0; i < 6; i++) begin
			host.set_pos(pos_tab[i]);
			ticks();
			chk("switch", exp_tab[i], sw);
			chk_rd("status", lsz_pkg::A_STATUS, exp_tab[i]);
		end
	endtask
	task automatic t_reload;
		host.wr(11'h087, 16'h0001);
		ticks();
		chk("switch", 16'h0002, sw);
		host.reload0();
		ticks();
		chk("switch", 16'h000a, sw);
	endtask
	task automatic t_error;
		host.wr32(lsz_pkg::A_SCALE_L, 32'h0000_01f4);
		repeat (4) @(posedge clk_i);
		chk("error", 16'h03f9, err);
		chk_rd("error word", lsz_pkg::A_ERROR, 16'h03f9);
		host.wr32(lsz_pkg::A_SCALE_L, lsz_pkg::SCALE_RST);
		repeat (4) @(posedge clk_i);
		chk("error", 16'h0000, err);
		// Lower range bound: channel 0 zone 0 starts below the new minimum
		host.wr(lsz_pkg::A_MIN_L, 16'h00c8);
		repeat (4) @(posedge clk_i);
		chk("error", 16'h03f5, err);
		chk_rd("minimum", lsz_pkg::A_MIN_L, 16'h00c8);
		host.wr(lsz_pkg::A_MIN_L, 16'h0000);
		repeat (4) @(posedge clk_i);
		chk("error", 16'h0000, err);
	endtask
	task automatic t_offline;
		host.set_ready(1'b0);
		repeat (3) @(posedge clk_i);
		chk("online", 16'h0000, {15'h0000, online});
		chk("switch", 16'h0000, sw);
		host.set_ready(1'b1);
		ticks();
		chk("switch", 16'h000a, sw);
		host.wr(lsz_pkg::A_OFFL, 16'h0001);
		host.set_ready(1'b0);
		ticks();
		chk("switch", 16'h000a, sw);
	endtask
	task automatic t_retain;
		logic [15:0] d;
		d = 16'h0001;
		host.wr(lsz_pkg::A_STORE, 16'h0001);
		for (int i = 0; i < 1000 && d[0] !== 1'b0; i++) begin
			host.rd(lsz_pkg::A_STORE, d);
		end
		chk("store busy", 16'h0000, {15'h0000, d[0]});
		@(posedge clk_i);
		rstn_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		rstn_i <= 1'b1;
		chk("switch", 16'h0000, sw);
		host.select(16'h0001);
		host.set_ready(1'b1);
		ticks();
		chk("switch", 16'h000a, sw);
		chk_rd("answerback", lsz_pkg::A_ANSWER, 16'h0001);
		host.select(16'h0000);
		ticks();
		chk("switch", 16'h0000, sw);
		// A select above 9 is kept in the word but must not start a load
		host.wr(lsz_pkg::A_PSEL1, 16'h000c);
		chk_rd("answerback", lsz_pkg::A_ANSWER, 16'h0000);
		chk_rd("select", lsz_pkg::A_PSEL1, 16'h000c);
	endtask

	initial begin
		rstn_i = 1'b0;
		repeat (16) @(posedge clk_i);
		rstn_i <= 1'b1;
		t_reset();
		t_zones();
		t_reload();
		t_error();
		t_offline();
		t_retain();
		end_of_test();
	end
	// Run needs roughly 5000 cycles
	initial begin
		repeat (30000) @(posedge clk_i);
		bad_count++;
		end_of_test();
	end
endmodule // tb
